// ### verilog/hwc_pkg.sv
// Constants, register map and state layout of the hibernate/watchdog control block.
// Assumes one 100 MHz clock and a plain register port with 8-bit word addresses.
package hwc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 100;      // Core clock rate
  localparam int unsigned WDOG_BASE_MS     = 125;      // Shortest watchdog period, 0.125 s
  localparam int unsigned WDOG_BASE_CYCLES = WDOG_BASE_MS * 1000 * CLK_MHZ; // Cycles of it
  localparam logic [2:0]  WDOG_MAX_CODE    = 3'h5;     // Longest legal period code, 4 s

  // ****************************************************************
  // Register map, word addresses on the register port
  // ****************************************************************
  localparam logic [7:0] ADDR_WDOG_CTRL  = 8'h04;      // watchdog_and_system_control
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h05;      // sleep_state_control
  localparam logic [7:0] ADDR_KEY        = 8'h10;      // Security key
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h11;      // Sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h12;      // One enables the event
  localparam logic [7:0] ADDR_STATUS     = 8'h13;      // Live state, read only

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned WD_ACTION_LSB  = 4;          // watchdog_action_select [5:4]
  localparam int unsigned WD_PERIOD_LSB  = 0;          // watchdog_period_select [2:0]
  localparam int unsigned SL_HIBERNATE   = 15;         // Hibernate request
  localparam int unsigned SL_WDOG_EN     = 7;          // sleep_watchdog_enable
  localparam int unsigned SL_FULL_SEQ    = 6;          // sleep_exit_full_sequence
  localparam int unsigned SL_KEEP_REGS   = 5;          // sleep_exit_keep_registers
  localparam int unsigned SL_SYSRST_LVL  = 4;          // sleep_system_reset_level
  localparam int unsigned SL_IRQ_MASK    = 3;          // sleep_interrupt_mask
  localparam int unsigned SL_MEMORY_RESET_OUT_LVL  = 2;          // sleep_memory_reset_level
  localparam int unsigned SL_COMP_EN     = 1;          // sleep_supply_comparator_enable
  localparam int unsigned SL_TEMP_EN     = 0;          // sleep_temperature_monitor_enable
  localparam int unsigned IRQ_EXPIRY     = 0;          // watchdog_expiry_irq
  localparam int unsigned IRQ_RST_WAKE   = 1;          // watchdog_reset_wake_irq

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [1:0]  ACT_OFF        = 2'h0;       // Watchdog does nothing
  localparam logic [1:0]  ACT_IRQ        = 2'h1;       // Interrupt only
  localparam logic [1:0]  ACT_RESET      = 2'h2;       // Interrupt and system reset
  localparam logic [1:0]  ACT_TWO_STAGE  = 2'h3;       // Interrupt, then reset
  localparam logic [15:0] UNLOCK_KEY     = 16'h5A3C;   // Arbitrary unlock value
  localparam logic [1:0]  RST_ACTION     = 2'h0;       // Action after any reset
  localparam logic [2:0]  RST_PERIOD     = 3'h4;       // Period code after reset, 2 s
  localparam logic [7:0]  RST_SLEEP_CFG  = 8'h00;      // Low sleep bits after reset
  localparam logic [1:0]  RST_IRQ_MASK   = 2'h0;       // All events masked after reset

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  wdogAction;        // Timeout action
    logic [2:0]  wdogPeriod;        // Period code
    logic        hibernate;         // Hibernate selected
    logic [7:0]  sleepCfg;          // Hibernate behaviour bits
    logic        unlocked;          // Security key open
    logic [31:0] timer;             // Down counter to expiry
    logic        stage;             // First two-stage expiry seen
    logic        kaPrev;            // Last keepalive level
    logic [1:0]  irqStatus;         // Sticky events
    logic [1:0]  irqMask;           // Event enables
    logic [15:0] rdData;            // Read answer
    logic        irqOut;            // Interrupt pin level
    logic        sysResetN;         // System reset pin
    logic        memResetN;         // memory_reset_out pin
    logic        compEn;            // Supply comparator enable
    logic        tempEn;            // Temperature monitor enable
    logic        wdogResetPulse;    // Watchdog system reset request
    logic        fullStartupPulse;  // Exit through startup sequence
    logic        regResetPulse;     // Internal register reset
  } hwc_state_s;

endpackage

// ### verilog/hwc_hibernate_watchdog.sv
// Watchdog timer and hibernate-state control with a plain register port.
// Assumes inputs synchronous to clk; the power state machine sits outside
// and acts on the request pulses; the host kicks the timer in time.
//
// Notes on behaviour
// R1 - Action 00 idle; 01 raises expiry interrupt
// R2 - Action 10: wake interrupt plus system reset
// R3 - Action 11: interrupt first, reset second expiry
// R4 - Action and period writable only when unlocked
// R5 - Keepalive edge or control write reloads timer
// R6 - Period 0.125 s doubling to 4 s
// R7 - Hibernate bit selects state, cleared by resets
// R8 - Watchdog off in hibernate unless enabled
// R9 - Exit takes full startup when selected
// R10 - Exit resets registers unless kept
// R11 - System reset pin level in hibernate
// R12 - Interrupt pin forced quiet in hibernate
// R13 - Memory reset pin level in hibernate
// R14 - Supply comparator kept in hibernate when set
// R15 - Temperature monitor kept in hibernate when set
// R16 - Two-stage mode reloads after first expiry
//
// Chosen here: strobed register access.
`timescale 1ns/10ps

module hwc_hibernate_watchdog #(
  parameter int unsigned BASE_PERIOD_CYCLES = hwc_pkg::WDOG_BASE_CYCLES // 0.125 s in cycles
) (
  input  wire logic        clk,               // 100 MHz core clock
  input  wire logic        reset,             // Asynchronous, active high
  input  wire logic [7:0]  addr,              // Register word address
  input  wire logic [15:0] wrData,            // Write data
  input  wire logic        wrEn,              // Write strobe
  input  wire logic        rdEn,              // Read strobe
  output logic      [15:0] rdData,            // Read data, cycle after strobe
  input  wire logic        keepalivePulse,    // Host keepalive_pulse level
  input  wire logic        smReset,           // Reset from the power state machine
  output logic             irqOut,            // Interrupt, active high
  output logic             sysResetOutN,      // System reset pin, active low
  output logic             memoryResetOutN,   // Memory reset pin, active low
  output logic             supplyCompEnable,  // Supply comparator enable
  output logic             tempMonEnable,     // Temperature monitor enable
  output logic             hibernateOut,      // Hibernate state selected
  output logic             wdogResetReq,      // One-cycle system reset request
  output logic             fullStartupReq,    // One-cycle full startup request
  output logic             regResetReq        // One-cycle register reset request
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Reload value: period minus one, so expiry falls a full period later
  function automatic logic [31:0] reloadValue(input logic [2:0] code);
    logic [2:0] clamped;
    clamped = (code > hwc_pkg::WDOG_MAX_CODE) ? hwc_pkg::WDOG_MAX_CODE : code;
    // Reserved codes behave as the longest period, the safer side
    return (32'(BASE_PERIOD_CYCLES) << clamped) - 32'h1; // R6
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  hwc_pkg::hwc_state_s s_q;    // Registered state
  hwc_pkg::hwc_state_s s_d;    // Next state
  logic                kick;   // Timer reload event
  logic                wdActive; // Watchdog counting
  logic                expireNow; // Timer runs out this cycle

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // All register, watchdog and pin behaviour in one pass
  always_comb begin
    s_d                  = s_q;
    s_d.wdogResetPulse   = 1'b0;
    s_d.fullStartupPulse = 1'b0;
    s_d.regResetPulse    = 1'b0;
    s_d.kaPrev           = keepalivePulse;
    // Either keepalive edge, or any control write even when locked
    kick = (keepalivePulse != s_q.kaPrev)
        || (wrEn && addr == hwc_pkg::ADDR_WDOG_CTRL); // R5
    // Hibernate stops the watchdog unless it is kept running
    wdActive = (s_q.wdogAction != hwc_pkg::ACT_OFF)
        && (!s_q.hibernate || s_q.sleepCfg[hwc_pkg::SL_WDOG_EN]); // R1 R8
    // A kick in the same cycle rescues the host
    expireNow = wdActive && (s_q.timer == 32'h0) && !kick;

    // Register writes
    if (wrEn) begin
      case (addr)
        hwc_pkg::ADDR_WDOG_CTRL: begin
          // Locked writes only kick the timer
          if (s_q.unlocked) begin
            s_d.wdogAction = wrData[hwc_pkg::WD_ACTION_LSB +: 2]; // R4
            s_d.wdogPeriod = wrData[hwc_pkg::WD_PERIOD_LSB +: 3]; // R4
          end
        end
        hwc_pkg::ADDR_SLEEP_CTRL: begin
          s_d.hibernate = wrData[hwc_pkg::SL_HIBERNATE]; // R7
          s_d.sleepCfg  = wrData[7:0];
        end
        hwc_pkg::ADDR_KEY: begin
          // Any other value locks again
          s_d.unlocked = (wrData == hwc_pkg::UNLOCK_KEY); // R4
        end
        hwc_pkg::ADDR_IRQ_STAT: begin
          // Clear first; events below win over it
          s_d.irqStatus = s_q.irqStatus & ~wrData[1:0];
        end
        hwc_pkg::ADDR_IRQ_MASK: begin
          s_d.irqMask = wrData[1:0];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // Watchdog timer
    if (kick) begin
      // Reload with the period being written, if any
      s_d.timer = reloadValue(s_d.wdogPeriod); // R5
      s_d.stage = 1'b0;
    end else if (!wdActive) begin
      // Parked full, so enabling starts a fresh period
      s_d.timer = reloadValue(s_q.wdogPeriod); // R8
      s_d.stage = 1'b0;
    end else if (expireNow) begin
      // Every action restarts the period
      s_d.timer = reloadValue(s_q.wdogPeriod); // R16
      case (s_q.wdogAction)
        hwc_pkg::ACT_IRQ: begin
          s_d.irqStatus[hwc_pkg::IRQ_EXPIRY] = 1'b1; // R1
        end
        hwc_pkg::ACT_RESET: begin
          s_d.irqStatus[hwc_pkg::IRQ_RST_WAKE] = 1'b1; // R2
          s_d.wdogResetPulse                   = 1'b1; // R2
        end
        hwc_pkg::ACT_TWO_STAGE: begin
          if (s_q.stage) begin
            s_d.irqStatus[hwc_pkg::IRQ_RST_WAKE] = 1'b1; // R3
            s_d.wdogResetPulse                   = 1'b1; // R3
            s_d.stage                            = 1'b0;
          end else begin
            s_d.irqStatus[hwc_pkg::IRQ_EXPIRY] = 1'b1; // R3
            s_d.stage                          = 1'b1; // R16
          end
        end
        default: begin
          // Off: unreachable while active
        end
      endcase
    end else begin
      s_d.timer = s_q.timer - 32'h1;
    end

    // Any system reset returns action and state to defaults
    if (smReset || s_d.wdogResetPulse) begin
      s_d.wdogAction = hwc_pkg::RST_ACTION; // R4
      s_d.hibernate  = 1'b0;                // R7
      s_d.stage      = 1'b0;
    end

    // Leaving hibernate: tell the state machine which way to go
    if (s_q.hibernate && !s_d.hibernate) begin
      s_d.fullStartupPulse = s_q.sleepCfg[hwc_pkg::SL_FULL_SEQ];   // R9
      s_d.regResetPulse    = !s_q.sleepCfg[hwc_pkg::SL_KEEP_REGS]; // R10
    end

    // Pins follow the next state so they change with it
    s_d.irqOut = |(s_d.irqStatus & s_d.irqMask)
        && !(s_d.hibernate && s_d.sleepCfg[hwc_pkg::SL_IRQ_MASK]); // R12
    s_d.sysResetN = !(s_d.wdogResetPulse
        || (s_d.hibernate && !s_d.sleepCfg[hwc_pkg::SL_SYSRST_LVL])); // R11
    s_d.memResetN = !(s_d.hibernate && !s_d.sleepCfg[hwc_pkg::SL_MEMORY_RESET_OUT_LVL]); // R13
    s_d.compEn = !s_d.hibernate || s_d.sleepCfg[hwc_pkg::SL_COMP_EN]; // R14
    s_d.tempEn = !s_d.hibernate || s_d.sleepCfg[hwc_pkg::SL_TEMP_EN]; // R15

    // Read answer, valid only in the cycle after the strobe
    s_d.rdData = 16'h0000;
    if (rdEn) begin
      case (addr)
        hwc_pkg::ADDR_WDOG_CTRL: begin
          s_d.rdData[hwc_pkg::WD_ACTION_LSB +: 2] = s_q.wdogAction;
          s_d.rdData[hwc_pkg::WD_PERIOD_LSB +: 3] = s_q.wdogPeriod;
        end
        hwc_pkg::ADDR_SLEEP_CTRL: begin
          s_d.rdData[hwc_pkg::SL_HIBERNATE] = s_q.hibernate;
          s_d.rdData[7:0]                   = s_q.sleepCfg;
        end
        hwc_pkg::ADDR_KEY: begin
          s_d.rdData[0] = s_q.unlocked;
        end
        hwc_pkg::ADDR_IRQ_STAT: begin
          s_d.rdData[1:0] = s_q.irqStatus;
        end
        hwc_pkg::ADDR_IRQ_MASK: begin
          s_d.rdData[1:0] = s_q.irqMask;
        end
        hwc_pkg::ADDR_STATUS: begin
          s_d.rdData[2:0] = {s_q.hibernate, s_q.stage, wdActive};
        end
        default: begin
          // Unmapped reads return zero
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset puts every field at its default
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q                  <= '0;
      s_q.wdogAction       <= hwc_pkg::RST_ACTION;
      s_q.wdogPeriod       <= hwc_pkg::RST_PERIOD;
      s_q.sleepCfg         <= hwc_pkg::RST_SLEEP_CFG;
      s_q.irqMask          <= hwc_pkg::RST_IRQ_MASK;
      s_q.timer            <= 32'((BASE_PERIOD_CYCLES << hwc_pkg::RST_PERIOD) - 1);
      s_q.sysResetN        <= 1'b1;
      s_q.memResetN        <= 1'b1;
      s_q.compEn           <= 1'b1;
      s_q.tempEn           <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Ports straight from the state flops
  assign rdData           = s_q.rdData;
  assign irqOut           = s_q.irqOut;
  assign sysResetOutN     = s_q.sysResetN;
  assign memoryResetOutN  = s_q.memResetN;
  assign supplyCompEnable = s_q.compEn;
  assign tempMonEnable    = s_q.tempEn;
  assign hibernateOut     = s_q.hibernate;
  assign wdogResetReq     = s_q.wdogResetPulse;
  assign fullStartupReq   = s_q.fullStartupPulse;
  assign regResetReq      = s_q.regResetPulse;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Mode off never raises anything
  chk_off_no_event: assert property ( // R1
    (s_q.wdogAction == hwc_pkg::ACT_OFF && !wrEn && !smReset)
      |=> !$rose(s_q.irqStatus[hwc_pkg::IRQ_EXPIRY]) && !s_q.wdogResetPulse)
    else $error("watchdog acted while off");

  // Interrupt-only mode never resets
  chk_irq_only_mode: assert property ( // R1
    (expireNow && s_q.wdogAction == hwc_pkg::ACT_IRQ)
      |=> s_q.irqStatus[hwc_pkg::IRQ_EXPIRY] && !s_q.wdogResetPulse)
    else $error("interrupt-only expiry wrong");

  // Reset mode: pulse, wake flag and pin together
  chk_reset_mode_out: assert property ( // R2
    (expireNow && s_q.wdogAction == hwc_pkg::ACT_RESET)
      |=> s_q.wdogResetPulse && s_q.irqStatus[hwc_pkg::IRQ_RST_WAKE] && !s_q.sysResetN
          ##1 !s_q.wdogResetPulse)
    else $error("reset-mode expiry wrong");

  // Two-stage: first expiry only interrupts and arms
  chk_two_stage_first: assert property ( // R3
    (expireNow && s_q.wdogAction == hwc_pkg::ACT_TWO_STAGE && !s_q.stage && !smReset)
      |=> s_q.stage && !s_q.wdogResetPulse && s_q.irqStatus[hwc_pkg::IRQ_EXPIRY])
    else $error("first two-stage expiry wrong");

  // Two-stage: second expiry resets
  chk_two_stage_second: assert property ( // R3
    (expireNow && s_q.wdogAction == hwc_pkg::ACT_TWO_STAGE && s_q.stage)
      |=> s_q.wdogResetPulse && s_q.irqStatus[hwc_pkg::IRQ_RST_WAKE])
    else $error("second two-stage expiry wrong");

  // Locked writes leave the period alone
  chk_key_locked_hold: assert property ( // R4
    (wrEn && addr == hwc_pkg::ADDR_WDOG_CTRL && !s_q.unlocked)
      |=> s_q.wdogPeriod == $past(s_q.wdogPeriod))
    else $error("locked write changed period");

  // Kick loads the full period
  chk_kick_reload_full: assert property ( // R5 R6
    kick |=> s_q.timer == reloadValue(s_q.wdogPeriod))
    else $error("kick did not reload timer");

  // After first stage the timer restarts full
  chk_stage_reload: assert property ( // R16
    (expireNow && s_q.wdogAction == hwc_pkg::ACT_TWO_STAGE && !s_q.stage)
      |=> s_q.timer == reloadValue(s_q.wdogPeriod))
    else $error("two-stage reload missing");

  // State machine reset leaves active state
  chk_sm_reset_hib: assert property ( // R7
    smReset |=> !s_q.hibernate && s_q.wdogAction == hwc_pkg::RST_ACTION)
    else $error("state machine reset missed");

  // Hibernate without enable raises no watchdog event at all
  chk_hib_wdog_off: assert property ( // R8
    (s_q.hibernate && !s_q.sleepCfg[hwc_pkg::SL_WDOG_EN])
      |=> !$rose(s_q.irqStatus[hwc_pkg::IRQ_EXPIRY]) && !s_q.wdogResetPulse)
    else $error("watchdog ran in hibernate");

  // Exit pulses match the selection bits
  chk_exit_requests: assert property ( // R9 R10
    $fell(s_q.hibernate)
      |-> s_q.fullStartupPulse == $past(s_q.sleepCfg[hwc_pkg::SL_FULL_SEQ])
          && s_q.regResetPulse == !$past(s_q.sleepCfg[hwc_pkg::SL_KEEP_REGS]))
    else $error("hibernate exit request wrong");

  // Pin levels during hibernate
  chk_hib_pin_levels: assert property ( // R11 R13 R14 R15
    (s_q.hibernate && !s_q.wdogResetPulse)
      |-> s_q.sysResetN == s_q.sleepCfg[hwc_pkg::SL_SYSRST_LVL]
          && s_q.memResetN == s_q.sleepCfg[hwc_pkg::SL_MEMORY_RESET_OUT_LVL]
          && s_q.compEn == s_q.sleepCfg[hwc_pkg::SL_COMP_EN]
          && s_q.tempEn == s_q.sleepCfg[hwc_pkg::SL_TEMP_EN])
    else $error("hibernate pin level wrong");

  // Interrupt pin forced quiet in hibernate
  chk_irq_forced_low: assert property ( // R12
    (s_q.hibernate && s_q.sleepCfg[hwc_pkg::SL_IRQ_MASK]) |-> !s_q.irqOut)
    else $error("interrupt seen while forced quiet");

  // Unforced hibernate leaves the interrupt pin normal
  chk_hib_irq_normal: assert property ( // R12
    (s_q.hibernate && !s_q.sleepCfg[hwc_pkg::SL_IRQ_MASK])
      |-> s_q.irqOut == |(s_q.irqStatus & s_q.irqMask))
    else $error("interrupt pin not normal in hibernate");

  // Reset and full startup request pulses last one cycle only
  chk_pulse_one_cycle: assert property ( // R2 R9
    (s_q.wdogResetPulse || s_q.fullStartupPulse)
      |=> !s_q.wdogResetPulse && !s_q.fullStartupPulse)
    else $error("request pulse stretched");

  // Main scenarios
  cov_two_stage_reset: cover property (
    s_q.wdogAction == hwc_pkg::ACT_TWO_STAGE && s_q.stage && expireNow);
  cov_hib_exit_full: cover property ($fell(s_q.hibernate) && s_q.fullStartupPulse);
  cov_kick_in_hib: cover property (s_q.hibernate && wdActive && kick);
  cov_locked_kick: cover property (wrEn && addr == hwc_pkg::ADDR_WDOG_CTRL && !s_q.unlocked);

endmodule

// ### testbench/hwc_host_model.sv
// Host keepalive_pulse source for the watchdog block.
// Assumes the bench gates it and picks the kick spacing in cycles.
`timescale 1ns/10ps

module hwc_host_model (
  input  wire logic       clk,            // Core clock
  input  wire logic       reset,          // Asynchronous, active high
  input  wire logic       kickEn,         // Keepalive_pulse running
  input  wire logic [3:0] kickGap,        // Cycles between kicks, minus one
  output logic            keepalivePulse  // Keepalive_pulse level, each change a kick
);
  // ****************************************************************
  // Keepalive_pulse toggler
  // ****************************************************************
  logic [3:0] gapCnt_q;                   // Cycles since last kick

  // Toggle once per gap; a slow gap lets the timer run out on purpose
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gapCnt_q       <= 4'h0;
      keepalivePulse <= 1'b0;
    end else if (!kickEn) begin
      gapCnt_q <= 4'h0;                   // Level holds, no kick while idle
    end else if (gapCnt_q == kickGap) begin
      gapCnt_q       <= 4'h0;
      keepalivePulse <= ~keepalivePulse;
    end else begin
      gapCnt_q <= gapCnt_q + 4'h1;
    end
  end
endmodule

// ### testbench/hwc_hibernate_watchdog_tb_top.sv
// Self-checking bench of the hibernate/watchdog control block.
// Assumes a shortened base period of 8 cycles and a host keepalive_pulse model.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errorCnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITFOR(s) for (n = 0; n < 20 && (s) !== 1'b1; n++) begin @(posedge clk); #1; end

module hwc_hibernate_watchdog_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, reset, wrEn, rdEn, smReset, kickEn, keepalivePulse, irqOut, sysResetOutN;
  logic memoryResetOutN, supplyCompEnable, tempMonEnable, hibernateOut;
  logic wdogResetReq, fullStartupReq, regResetReq;
  logic [7:0] addr;                       // Register address
  logic [15:0] wrData, rdData, got;       // Bus data and last read
  logic [3:0] kickGap;                    // Keepalive_pulse spacing
  int errorCnt = 0, checks = 0, n, i;     // Counters
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} hwc_row_s;
  hwc_row_s rows [7] = '{'{8'h10, 16'h5A3C, 16'h0001}, '{8'h12, 16'h0003, 16'h0003},
    '{8'h04, 16'h0005, 16'h0005}, '{8'h04, 16'h0000, 16'h0000},
    '{8'h05, 16'h00FF, 16'h00FF}, '{8'h05, 16'h0000, 16'h0000},
    '{8'h20, 16'hFFFF, 16'h0000}};        // Write value, expected read back

  hwc_hibernate_watchdog #(.BASE_PERIOD_CYCLES(8)) uut (.clk(clk), .reset(reset), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .keepalivePulse(keepalivePulse), .smReset(smReset), .irqOut(irqOut),
    .sysResetOutN(sysResetOutN), .memoryResetOutN(memoryResetOutN),
    .supplyCompEnable(supplyCompEnable), .tempMonEnable(tempMonEnable),
    .hibernateOut(hibernateOut), .wdogResetReq(wdogResetReq),
    .fullStartupReq(fullStartupReq), .regResetReq(regResetReq));
  hwc_host_model host (.clk(clk), .reset(reset), .kickEn(kickEn), .kickGap(kickGap),
    .keepalivePulse(keepalivePulse));

  // ****************************************************************
  // Bus tasks and verdict
  // ****************************************************************
  // One-cycle write; pins are settled on return
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wrData <= d; wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 got = rdData;
  endtask
  task automatic printVerdict;
    $display("Comparisons %0d, mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Clock of 10 ns and a watchdog against hangs
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    errorCnt++;
    printVerdict;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1; addr = 8'h00; wrData = 16'h0000; wrEn = 1'b0; rdEn = 1'b0;
    smReset = 1'b0; kickEn = 1'b0; kickGap = 4'h3;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK({hibernateOut, sysResetOutN, memoryResetOutN, irqOut}, 4'h6)
    rd(8'h04); `CHK(got, 16'h0004)
    // Table: write then read back, unmapped place reads zero
    for (i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a); `CHK(got, rows[i].e)
    end
    // Locked writes leave action and period alone
    wr(8'h10, 16'h0000); wr(8'h04, 16'h0021); rd(8'h04); `CHK(got, 16'h0000)
    wr(8'h10, 16'h5A3C); repeat (20) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    // Interrupt only mode, then masking and clearing
    wr(8'h04, 16'h0010); repeat (4) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    `WAITFOR(irqOut) `CHK(irqOut, 1'b1)
    `CHK(wdogResetReq, 1'b0)
    wr(8'h12, 16'h0000); `CHK(irqOut, 1'b0)
    wr(8'h04, 16'h0010); wr(8'h11, 16'h0003); kickEn <= 1'b1;
    repeat (30) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    wr(8'h12, 16'h0003); `CHK(irqOut, 1'b0)
    kickEn <= 1'b0;
    `WAITFOR(irqOut) `CHK(irqOut, 1'b1)
    // Two-stage mode: interrupt, then reset one period later
    wr(8'h04, 16'h0030); wr(8'h11, 16'h0003);
    `WAITFOR(irqOut) `CHK(wdogResetReq, 1'b0)
    rd(8'h11); `CHK(got, 16'h0001)
    `WAITFOR(wdogResetReq) `CHK(wdogResetReq, 1'b1)
    `CHK(n, 6)
    `CHK(sysResetOutN, 1'b0)
    // Reset mode: wake event, reset pulse, action returned to off
    wr(8'h11, 16'h0003); wr(8'h04, 16'h0020); `WAITFOR(wdogResetReq)
    `CHK({wdogResetReq, sysResetOutN}, 2'h2)
    @(posedge clk);
    #1 `CHK({wdogResetReq, sysResetOutN}, 2'h1)
    rd(8'h11); `CHK(got, 16'h0002)
    rd(8'h04); `CHK(got, 16'h0000)
    // Hibernate with everything low, watchdog stopped
    wr(8'h11, 16'h0003); wr(8'h04, 16'h0010); wr(8'h05, 16'h8040);
    `CHK({hibernateOut, sysResetOutN, memoryResetOutN}, 3'h4)
    `CHK({supplyCompEnable, tempMonEnable}, 2'h0)
    repeat (30) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    wr(8'h05, 16'h0000); `CHK({hibernateOut, fullStartupReq, regResetReq}, 3'h3)
    `CHK({sysResetOutN, memoryResetOutN, supplyCompEnable}, 3'h7)
    // Hibernate keeping registers and pins, interrupt pin quiet
    wr(8'h05, 16'h80BF);
    `CHK({sysResetOutN, memoryResetOutN, supplyCompEnable, tempMonEnable}, 4'hF)
    repeat (30) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    rd(8'h11); `CHK(got[0], 1'b1)
    wr(8'h05, 16'h0000); `CHK({fullStartupReq, regResetReq}, 2'h0)
    `CHK(irqOut, 1'b1)
    // State machine reset leaves hibernate
    wr(8'h05, 16'h8000);
    @(posedge clk); smReset <= 1'b1;
    @(posedge clk); smReset <= 1'b0;
    @(posedge clk); #1 `CHK(hibernateOut, 1'b0)
    // Period code 1 doubles the base period to 16 cycles
    wr(8'h11, 16'h0003); wr(8'h04, 16'h0011);
    repeat (15) @(posedge clk); #1 `CHK(irqOut, 1'b0)
    @(posedge clk); #1 `CHK(irqOut, 1'b1)
    // Mid-run reset: defaults back, key locked, events gone
    @(posedge clk); reset <= 1'b1;
    repeat (2) @(posedge clk); reset <= 1'b0;
    #1 `CHK({hibernateOut, sysResetOutN, memoryResetOutN, irqOut}, 4'h6)
    `CHK({supplyCompEnable, tempMonEnable}, 2'h3)
    rd(8'h10); `CHK(got, 16'h0000)
    rd(8'h04); `CHK(got, 16'h0004)
    printVerdict;
  end
endmodule
